// ### ctmc_regs.vh
// Constants for the CAN transceiver mode control block.
// Included by the design and its bench; definitions only.
`ifndef CTMC_REGS_VH
`define CTMC_REGS_VH
// ******************************
// Register offsets (byte addresses)
// ******************************
`define CTMC_OFF_CTRL 4'h0
`define CTMC_OFF_STAT 4'h4
`define CTMC_OFF_IRQ_STAT 4'h8
`define CTMC_OFF_IRQ_MASK 4'hC
// ******************************
// Transceiver mode codes
// ******************************
`define CTMC_MODE_OFF 2'h0
`define CTMC_MODE_WAKE 2'h1
`define CTMC_MODE_NORM 2'h3
`define CTMC_MODE_RXO 2'h2
// ******************************
// Chip operating modes
// ******************************
`define CTMC_CHIP_NORMAL 3'h0
`define CTMC_CHIP_STOP 3'h1
`define CTMC_CHIP_SLEEP 3'h2
`define CTMC_CHIP_RESTART 3'h3
`define CTMC_CHIP_FAILSAFE 3'h4
// ******************************
// Field positions
// ******************************
`define CTMC_CTRL_MODE_LSB 0
`define CTMC_CTRL_MODE_MSB 1
`define CTMC_STAT_SETTLED 2
`define CTMC_STAT_WOKEN 3
`define CTMC_IRQ_WAKE 0
`define CTMC_IRQ_SETTLED 1
`define CTMC_IRQ_REFUSED 2
// ******************************
// Timing
// ******************************
`define CTMC_SETTLE_NS 10000
`define CTMC_CLK_NS 5
`define CTMC_WAKE_MIN_NS 500
`endif

// ### ctmc_top.v
// Mode control and digital data path of a CAN FD transceiver.
// Assumes an Avalon-MM master on core_clk and bus comparator/driver outside.
`timescale 1ns/100ps
`include "ctmc_regs.vh"
// Function
// - Off mode after reset until software selects
// - Off mode selectable in every chip mode
// - Off mode ignores bus wake activity
// - Normal mode only in chip normal mode
// - Settling interval before first dominant drive
// - Only dominant begun after settling transmitted
// - Normal mode: transmit low drives dominant
// - Receive output low dominant, high recessive
// - Wake-capable mode: bus message wakes chip
// - Receive-only mode offered for diagnostics
// - Path supports up to 2 Mbaud
// - Receive-only: driver off, receive forwarded
// - After wake, receive low until mode change, unless chip re-arm comes in the wake cycle
// - Mode field still reads wake code after wake
// - Mode upper bit set for normal, receive-only
module ctmc_top #(
   parameter SETTLE_CYC = (`CTMC_SETTLE_NS + `CTMC_CLK_NS - 1) / `CTMC_CLK_NS,
   parameter WAKE_CYC = (`CTMC_WAKE_MIN_NS + `CTMC_CLK_NS - 1) / `CTMC_CLK_NS
) (
   input wire core_clk, // 200 MHz clock
   input wire reset_n, // Synchronous reset, active low
   input wire [3:0] avs_address, // Byte address
   input wire avs_read, // Read strobe
   input wire avs_write, // Write strobe
   input wire [31:0] avs_writedata, // Write data
   input wire [3:0] avs_byteenable, // Byte lanes
   output reg [31:0] avs_readdata, // Read data
   output reg avs_waitrequest, // Stall
   input wire [2:0] chip_mode, // Chip operating mode, same clock
   input wire tx_data_in, // Host transmit pin, async
   output reg rx_data_out, // Receive pin to host
   input wire bus_dominant_in, // Comparator: bus differential dominant, async
   output reg bus_drive_dom, // Driver: force dominant
   output reg wake_event, // One-cycle wake pulse toward the chip
   output reg irq // Level interrupt
);
   // ******************************
   // Local constants
   // ******************************
   localparam N_SYNC = 2;
   localparam SYNC_TX = 0;
   localparam SYNC_BUS = 1;
   localparam IRQ_W = 3;
   // Pins idle at transmit high and bus recessive, so no false edge after reset
   localparam [N_SYNC-1:0] SYNC_IDLE = 2'b01;

   // ******************************
   // Input synchronisers
   // ******************************
   wire [N_SYNC-1:0] pin_raw = {bus_dominant_in, tx_data_in};
   wire [N_SYNC-1:0] pin_sync;
   genvar g;
   generate
      for (g = 0; g < N_SYNC; g = g + 1) begin : g_sync
         reg s1_r;
         reg s2_r;
         always @(posedge core_clk) begin
            if (!reset_n) begin
               s1_r <= SYNC_IDLE[g];
               s2_r <= SYNC_IDLE[g];
            end else begin
               s1_r <= pin_raw[g];
               s2_r <= s1_r;
            end
         end
         assign pin_sync[g] = s2_r;
      end
   endgenerate
   // Only the second stage is read from here on
   wire tx_sync = pin_sync[SYNC_TX];
   wire bus_sync = pin_sync[SYNC_BUS];

   // ******************************
   // Decode helpers
   // ******************************
   // Address match, shared by every register select
   function addr_is;
      input [3:0] a;
      input [3:0] off;
      begin
         addr_is = (a == off);
      end
   endfunction

   // Normal mode needs chip normal mode; every other code is always allowed
   function mode_legal;
      input [1:0] m;
      input [2:0] c;
      begin
         mode_legal = (m != `CTMC_MODE_NORM) || (c == `CTMC_CHIP_NORMAL);
      end
   endfunction

   // Chip modes whose entry re-arms wake detection
   function chip_rearms;
      input [2:0] c;
      begin
         chip_rearms = (c == `CTMC_CHIP_STOP) || (c == `CTMC_CHIP_SLEEP) || (c == `CTMC_CHIP_FAILSAFE);
      end
   endfunction

   // Modes that forward the bus to the receive output
   function mode_listens;
      input [1:0] m;
      begin
         mode_listens = (m == `CTMC_MODE_NORM) || (m == `CTMC_MODE_RXO);
      end
   endfunction

   // Status word: woken, settled, then the mode field
   function [31:0] stat_word;
      input [1:0] m;
      input s;
      input w;
      begin
         stat_word = {28'h0, w, s, m};
      end
   endfunction

   // ******************************
   // Register state
   // ******************************
   reg [1:0] mode_r;
   reg [1:0] mode_nxt;
   reg [31:0] settle_cnt_r;
   reg settled_r;
   reg armed_r;
   reg woken_r;
   reg [31:0] wake_cnt_r;
   reg [IRQ_W-1:0] irq_stat_r;
   reg [IRQ_W-1:0] irq_mask_r;
   reg [IRQ_W-1:0] irq_stat_nxt;
   reg [2:0] chip_prev_r;
   reg ack_r;
   reg tx_gate_r;
   reg drive_nxt;
   reg rx_nxt;
   reg [31:0] rdata_nxt;

   // ******************************
   // Bus decode
   // ******************************
   // One take per request; ack_r keeps a held request from being taken twice
   wire acc = (avs_read | avs_write) & ~ack_r;
   wire wr = avs_write & acc & avs_byteenable[0];
   wire rd = avs_read & acc;
   wire hit_ctrl = addr_is(avs_address, `CTMC_OFF_CTRL);
   wire hit_stat = addr_is(avs_address, `CTMC_OFF_STAT);
   wire hit_istat = addr_is(avs_address, `CTMC_OFF_IRQ_STAT);
   wire hit_imask = addr_is(avs_address, `CTMC_OFF_IRQ_MASK);
   wire [1:0] req_mode = avs_writedata[`CTMC_CTRL_MODE_MSB:`CTMC_CTRL_MODE_LSB];
   wire mode_ok = mode_legal(req_mode, chip_mode);
   wire mode_wr = wr & hit_ctrl & mode_ok;
   wire refused = wr & hit_ctrl & ~mode_ok;
   wire enter_norm = mode_wr & (req_mode == `CTMC_MODE_NORM) & (mode_r != `CTMC_MODE_NORM);
   wire mode_change = mode_wr & (req_mode != mode_r);
   wire rd_istat = rd & hit_istat;
   wire chip_left_normal = (mode_r == `CTMC_MODE_NORM) & (chip_mode != `CTMC_CHIP_NORMAL);
   wire rearm_chip = (chip_mode != chip_prev_r) & chip_rearms(chip_mode);
   // Long dominant counts as qualifying message; full pattern filter not modelled
   wire wake_hit = (mode_r == `CTMC_MODE_WAKE) & armed_r & bus_sync &
      (wake_cnt_r == WAKE_CYC - 1);
   wire settle_done = (mode_r == `CTMC_MODE_NORM) & ~settled_r & (settle_cnt_r == SETTLE_CYC - 1);
   wire [IRQ_W-1:0] ev = {refused, settle_done, wake_hit};

   // ******************************
   // Transceiver mode
   // ******************************
   always @* begin
      mode_nxt = mode_r;
      if (mode_wr)
         mode_nxt = req_mode;
      else if (chip_left_normal)
         mode_nxt = `CTMC_MODE_WAKE;
   end

   always @(posedge core_clk) begin
      if (!reset_n) begin
         mode_r <= `CTMC_MODE_OFF;
         chip_prev_r <= `CTMC_CHIP_NORMAL;
      end else begin
         mode_r <= mode_nxt;
         chip_prev_r <= chip_mode;
      end
   end

   // ******************************
   // Enable settling
   // ******************************
   // Restarts on every entry, so a quick off and on cannot skip the wait
   always @(posedge core_clk) begin
      if (!reset_n) begin
         settle_cnt_r <= 32'h0;
         settled_r <= 1'b0;
      end else if (enter_norm || mode_r != `CTMC_MODE_NORM) begin
         settle_cnt_r <= 32'h0;
         settled_r <= 1'b0;
      end else if (settle_done) begin
         settled_r <= 1'b1;
      end else if (!settled_r) begin
         settle_cnt_r <= settle_cnt_r + 32'h1;
      end
   end

   // ******************************
   // Wake detection
   // ******************************
   always @(posedge core_clk) begin
      if (!reset_n)
         wake_cnt_r <= 32'h0;
      else if (mode_r == `CTMC_MODE_WAKE && armed_r && bus_sync)
         wake_cnt_r <= wake_cnt_r + 32'h1;
      else
         wake_cnt_r <= 32'h0;
   end

   // Re-arming keeps the woken state, so receive stays low until a write changes the mode
   always @(posedge core_clk) begin
      if (!reset_n) begin
         armed_r <= 1'b0;
         woken_r <= 1'b0;
         wake_event <= 1'b0;
      end else begin
         wake_event <= wake_hit;
         if (mode_change) begin
            armed_r <= (req_mode == `CTMC_MODE_WAKE);
            woken_r <= 1'b0;
         end else if (chip_left_normal) begin
            // Forced drop to wake-capable must still be able to wake
            armed_r <= 1'b1;
            woken_r <= 1'b0;
         end else if (rearm_chip && mode_r == `CTMC_MODE_WAKE) begin
            armed_r <= 1'b1;
         end else if (wake_hit) begin
            armed_r <= 1'b0;
            woken_r <= 1'b1;
         end else if (mode_r == `CTMC_MODE_NORM) begin
            armed_r <= 1'b0;
         end
      end
   end

   // ******************************
   // Data path
   // ******************************
   // Gate opens only once tx is seen high after settling, so an early low never leaks
   always @(posedge core_clk) begin
      if (!reset_n)
         tx_gate_r <= 1'b0;
      else if (mode_r != `CTMC_MODE_NORM || !settled_r)
         tx_gate_r <= 1'b0;
      else if (tx_sync)
         tx_gate_r <= 1'b1;
   end

   always @* begin
      drive_nxt = (mode_r == `CTMC_MODE_NORM) & tx_gate_r & ~tx_sync;
      rx_nxt = 1'b1;
      if (mode_listens(mode_r))
         rx_nxt = ~bus_sync;
      else if (mode_r == `CTMC_MODE_WAKE)
         rx_nxt = ~(woken_r | wake_hit);
   end

   always @(posedge core_clk) begin
      if (!reset_n) begin
         bus_drive_dom <= 1'b0;
         rx_data_out <= 1'b1;
      end else begin
         bus_drive_dom <= drive_nxt;
         rx_data_out <= rx_nxt;
      end
   end

   // ******************************
   // Interrupts
   // ******************************
   // Set wins over the read clear, so an event in the read cycle is not lost
   always @* begin
      irq_stat_nxt = irq_stat_r;
      if (rd_istat)
         irq_stat_nxt = {IRQ_W{1'b0}};
      irq_stat_nxt = irq_stat_nxt | ev;
   end

   always @(posedge core_clk) begin
      if (!reset_n) begin
         irq_stat_r <= {IRQ_W{1'b0}};
         irq_mask_r <= {IRQ_W{1'b0}};
         irq <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         if (wr && hit_imask)
            irq_mask_r <= avs_writedata[IRQ_W-1:0];
         irq <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   // ******************************
   // Bus slave
   // ******************************
   // Unmapped offsets read as zero
   always @* begin
      rdata_nxt = 32'h0;
      if (hit_ctrl)
         rdata_nxt = {30'h0, mode_r};
      else if (hit_stat)
         rdata_nxt = stat_word(mode_r, settled_r, woken_r);
      else if (hit_istat)
         rdata_nxt = {29'h0, irq_stat_r};
      else if (hit_imask)
         rdata_nxt = {29'h0, irq_mask_r};
   end

   // Waitrequest drops for one cycle per taken request
   always @(posedge core_clk) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         ack_r <= acc;
         avs_waitrequest <= ~acc;
         if (rd)
            avs_readdata <= rdata_nxt;
      end
   end
endmodule

// ### ctmc_top_asserts.sv
// Port-level checker for ctmc_top.
// Assumes a bind into ctmc_top; one clock domain.
`timescale 1ns/100ps
module ctmc_top_asserts #(
   parameter SETTLE_CYC = 20,
   parameter WAKE_CYC = 4
) (
   input wire core_clk, // Clock
   input wire reset_n, // Sync reset
   input wire avs_read, // Read strobe
   input wire avs_write, // Write strobe
   input wire [31:0] avs_readdata, // Read data
   input wire avs_waitrequest, // Stall
   input wire tx_data_in, // Host transmit
   input wire rx_data_out, // Receive pin
   input wire bus_dominant_in, // Bus state
   input wire bus_drive_dom, // Driver
   input wire wake_event // Wake pulse
);
   // Run length of dominant bus samples, for the wake filter length
   reg [31:0] dom_run_r;
   always @(posedge core_clk) begin
      if (!reset_n)
         dom_run_r <= 32'h0;
      else if (bus_dominant_in)
         dom_run_r <= dom_run_r + 32'h1;
      else
         dom_run_r <= 32'h0;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_read_hold: assert property (!avs_read && !$past(avs_read) |-> $stable(avs_readdata))
      else $error("read data changed without read");
   // Sync and output stages give the driver three cycles
   a_tx_release: assert property (tx_data_in [*6] |-> !bus_drive_dom)
      else $error("dominant drive with transmit high");
   a_rx_cause: assert property ($fell(rx_data_out) |-> $past(bus_dominant_in, 2) || $past(bus_dominant_in, 3)
      || $past(bus_dominant_in, 4) || $past(bus_dominant_in, 5)) else $error("receive low without dominant bus");
   a_wake_once: assert property (wake_event |=> !wake_event)
      else $error("wake pulse too long");
   a_wake_cause: assert property (wake_event |-> $past(bus_dominant_in, 4) && $past(bus_dominant_in, 5))
      else $error("wake without dominant bus");
   a_wake_rx: assert property (wake_event |=> !rx_data_out [*4])
      else $error("receive not low after wake");
   a_wake_length: assert property (wake_event |-> $past(dom_run_r, 2) >= WAKE_CYC)
      else $error("wake after too short a dominant");
endmodule
bind ctmc_top ctmc_top_asserts #(.SETTLE_CYC(SETTLE_CYC), .WAKE_CYC(WAKE_CYC)) u_chk (.core_clk(core_clk),
   .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .tx_data_in(tx_data_in), .rx_data_out(rx_data_out),
   .bus_dominant_in(bus_dominant_in), .bus_drive_dom(bus_drive_dom), .wake_event(wake_event));

// ### ctmc_host_model.sv
// Host protocol controller model driving the transmit pin.
// Assumes the bench steps en and bit_dom on core_clk.
`timescale 1ns/100ps
module ctmc_host_model (
   input wire clk, // Core clock
   input wire en, // Host may send dominant
   input wire bit_dom, // Next bit dominant
   output reg tx // Transmit pin
);
   initial tx = 1'b1;
   // Recessive unless the host believes settling is over
   always @(posedge clk) tx <= !(en && bit_dom);
endmodule

// ### ctmc_top_tb.sv
// Self-checking bench for ctmc_top.
// Assumes ctmc_top, its checker and the host model are compiled.
`timescale 1ns/100ps
`include "ctmc_regs.vh"
module ctmc_top_tb;
   reg core_clk = 0, reset_n = 0, avs_read = 0, avs_write = 0, en = 0, bdom = 0, other = 0;
   reg [3:0] avs_address = 4'h0;
   reg [31:0] avs_writedata = 32'h0, q = 32'h0, seed = 32'h765D0CEA;
   reg [2:0] chip_mode = `CTMC_CHIP_NORMAL;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, tx, rx_data_out, bus_drive_dom, wake_event, irq;
   wire bus = bus_drive_dom | other;
   integer n_fail = 0, total_checks = 0, i;
   always #2.5 core_clk = ~core_clk;
   ctmc_top #(.SETTLE_CYC(20), .WAKE_CYC(4)) dut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chip_mode(chip_mode), .tx_data_in(tx),
      .rx_data_out(rx_data_out), .bus_dominant_in(bus), .bus_drive_dom(bus_drive_dom), .wake_event(wake_event),
      .irq(irq));
   ctmc_host_model host (.clk(core_clk), .en(en), .bit_dom(bdom), .tx(tx));
   // ****
   // Helpers
   // ****
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   function exp_rx(input d, input o);
      exp_rx = !(d | o);
   endfunction
   task stop_test;
      begin
         $display("Checks %0d, mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Holds the request until waitrequest is seen low
   task acc(input wr, input [3:0] a, input [31:0] d);
      integer k;
      begin
         @(posedge core_clk);
         avs_address <= a;
         avs_writedata <= d;
         avs_write <= wr;
         avs_read <= !wr;
         k = 0;
         @(posedge core_clk);
         while (avs_waitrequest !== 1'b0 && k < 40) begin
            @(posedge core_clk);
            k = k + 1;
         end
         if (k == 40) begin
            n_fail = n_fail + 1;
            stop_test;
         end
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask
   // One bit lasts 100 cycles, the 2 Mbaud bit time
   task bits(input drv);
      for (i = 0; i < 20; i = i + 1) begin
         seed = xs(seed);
         en <= 1'b1;
         bdom <= seed[0];
         other <= seed[1] & seed[2];
         repeat (100) @(posedge core_clk);
         chk(bus_drive_dom, bdom & drv);
         chk(rx_data_out, exp_rx(bdom & drv, other));
      end
   endtask
   // ****
   // Sequence
   // ****
   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      acc(0, `CTMC_OFF_CTRL, 0);
      chk(q, `CTMC_MODE_OFF);
      other <= 1'b1;
      repeat (30) begin
         @(posedge core_clk);
         chk({rx_data_out, wake_event}, 2'h2);
      end
      other <= 1'b0;
      $display("Test off mode done");
      acc(1, `CTMC_OFF_IRQ_MASK, 0);
      chip_mode <= `CTMC_CHIP_STOP;
      acc(1, `CTMC_OFF_CTRL, `CTMC_MODE_NORM);
      repeat (4) @(posedge core_clk);
      chk(irq, 0);
      acc(1, `CTMC_OFF_IRQ_MASK, 32'h7);
      repeat (4) @(posedge core_clk);
      chk(irq, 1);
      acc(0, `CTMC_OFF_CTRL, 0);
      chk(q, `CTMC_MODE_OFF);
      acc(0, `CTMC_OFF_IRQ_STAT, 0);
      chk(q, 32'h4);
      repeat (4) @(posedge core_clk);
      chk(irq, 0);
      $display("Test refused normal done");
      chip_mode <= `CTMC_CHIP_NORMAL;
      en <= 1'b1;
      bdom <= 1'b1;
      acc(1, `CTMC_OFF_CTRL, `CTMC_MODE_NORM);
      repeat (40) begin
         @(posedge core_clk);
         chk(bus_drive_dom, 0);
      end
      en <= 1'b0;
      repeat (30) @(posedge core_clk);
      acc(0, `CTMC_OFF_STAT, 0);
      chk(q & 32'h7, 32'h7);
      acc(0, `CTMC_OFF_IRQ_STAT, 0);
      chk(q, 32'h2);
      bits(1);
      acc(1, `CTMC_OFF_CTRL, `CTMC_MODE_RXO);
      bits(0);
      acc(0, `CTMC_OFF_STAT, 0);
      chk(q & 32'h3, `CTMC_MODE_RXO);
      $display("Test data path done");
      en <= 1'b0;
      other <= 1'b0;
      acc(1, `CTMC_OFF_CTRL, `CTMC_MODE_NORM);
      acc(0, `CTMC_OFF_STAT, 0);
      chk(q & 32'h7, 32'h3);
      other <= 1'b1;
      acc(1, `CTMC_OFF_CTRL, `CTMC_MODE_WAKE);
      i = 0;
      while (wake_event !== 1'b1 && i < 60) begin
         @(posedge core_clk);
         i = i + 1;
      end
      chk(i < 60, 1);
      other <= 1'b0;
      repeat (20) @(posedge core_clk);
      chk(rx_data_out, 0);
      acc(0, `CTMC_OFF_STAT, 0);
      chk(q & 32'hB, 32'h9);
      acc(0, `CTMC_OFF_IRQ_STAT, 0);
      chk(q, 32'h1);
      chip_mode <= `CTMC_CHIP_SLEEP;
      acc(1, `CTMC_OFF_CTRL, `CTMC_MODE_OFF);
      acc(0, `CTMC_OFF_CTRL, 0);
      chk(q, `CTMC_MODE_OFF);
      repeat (4) @(posedge core_clk);
      chk(rx_data_out, 1);
      acc(0, 4'h2, 0);
      chk(q, 0);
      $display("Test wake done");
      stop_test;
   end
endmodule
